// ==== include/scf_pkg.sv ====
// ---------------------------------------------------------------------------
// Sinc3 decimation filter constants
// ---------------------------------------------------------------------------
package scf_pkg;

  // Modulator rate is the master clock divided by this
  localparam int MOD_DIV         = 128;
  localparam int PRESC_W         = 7;
  // Master clock figures, kept for reference scaling
  localparam int MCLK_PERIOD_NS  = 10;
  // Default decimation factors per rate code (modulator rate / output rate)
  localparam int DEC_N_CODE0     = 960;
  localparam int DEC_N_CODE1     = 768;
  localparam int DEC_N_CODE2     = 192;
  localparam int DEC_N_CODE3     = 96;
  localparam int DEC_CNT_W       = 10;
  // Sinc3 order and accumulator sizing
  localparam int SINC_ORDER      = 3;
  localparam int HEADROOM_BITS   = 1;
  localparam int ACC_W_DEF       = 32;
  // Words discarded before a settled word is released
  localparam logic [1:0] SKIP_FREE = 2'h3;
  localparam logic [1:0] SKIP_SYNC = 2'h2;
  // Output FIFO depth
  localparam int FIFO_DEPTH_DEF  = 4;

endpackage : scf_pkg

// ==== hw/scf_sinc3_filter.sv ====
`timescale 1ns/100ps

// ---------------------------------------------------------------------------
// Small synchronous FIFO
// ---------------------------------------------------------------------------
module scf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("scf_fifo DEPTH must be a power of 2");
  end

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [PTR_W:0]   count_ff;
  logic             push;
  logic             pop;

  // Honest full and empty flags from the fill count
  assign in_ready_o  = (count_ff != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem_ff[rd_ptr_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage write
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + PTR_W'(1);
      end
      count_ff <= count_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

  chk_fifo_no_overrun: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    count_ff <= (PTR_W+1)'(DEPTH))
    else $error("fifo count above depth");

endmodule : scf_fifo

// ---------------------------------------------------------------------------
// Sinc3 decimation filter top
// ---------------------------------------------------------------------------
module scf_sinc3_filter #(
  parameter int ACC_W      = scf_pkg::ACC_W_DEF,
  parameter int DEC_N0     = scf_pkg::DEC_N_CODE0,
  parameter int DEC_N1     = scf_pkg::DEC_N_CODE1,
  parameter int DEC_N2     = scf_pkg::DEC_N_CODE2,
  parameter int DEC_N3     = scf_pkg::DEC_N_CODE3,
  parameter int FIFO_DEPTH = scf_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic             mod_bit_i,
  input  wire logic             rate_select_lo_i,
  input  wire logic             rate_select_hi_i,
  input  wire logic             filter_resync_i,
  input  wire logic             out_ready_i,
  output logic                  mod_tick_o,
  output logic                  word_strobe_o,
  output logic                  out_valid_o,
  output logic [ACC_W-1:0]      out_data_o,
  output logic                  overrun_o
);
  import scf_pkg::*;

  localparam int NMAX = (DEC_N0 > DEC_N1 ? DEC_N0 : DEC_N1) > (DEC_N2 > DEC_N3 ? DEC_N2 : DEC_N3)
                      ? (DEC_N0 > DEC_N1 ? DEC_N0 : DEC_N1) : (DEC_N2 > DEC_N3 ? DEC_N2 : DEC_N3);

  // Accumulators must hold N^3 plus overrange headroom, else the combs alias
  if (ACC_W < SINC_ORDER * $clog2(NMAX + 1) + HEADROOM_BITS) begin : g_bad_acc_w
    $error("ACC_W too narrow for the largest decimation factor");
  end
  if (NMAX >= 2**DEC_CNT_W) begin : g_bad_cnt_w
    $error("decimation factor exceeds counter width");
  end
  if (DEC_N0 < 2 || DEC_N1 < 2 || DEC_N2 < 2 || DEC_N3 < 2) begin : g_bad_dec_n
    $error("decimation below 2");
  end

  // ---------------------------------------------------------------------------
  // Modulator sample clock
  // ---------------------------------------------------------------------------
  logic [PRESC_W-1:0] presc_ff;
  logic               mod_tick_ff;

  // Divide the master clock by 128 for the modulator sample rate
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || filter_resync_i) begin
      presc_ff    <= '0;
      mod_tick_ff <= 1'b0;
    end else begin
      presc_ff    <= presc_ff + PRESC_W'(1);
      mod_tick_ff <= (presc_ff == PRESC_W'(MOD_DIV - 1));
    end
  end
  assign mod_tick_o = mod_tick_ff;

  // ---------------------------------------------------------------------------
  // Rate selection
  // ---------------------------------------------------------------------------
  logic [1:0]           rate_ff;
  logic [1:0]           rate_now;
  logic                 rate_change;
  logic [DEC_CNT_W-1:0] dec_n;

  assign rate_now    = {rate_select_hi_i, rate_select_lo_i};
  assign rate_change = (rate_now != rate_ff);

  // Pins are synchronous, so a plain register tracks the selected code
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rate_ff <= 2'h0;
    end else begin
      rate_ff <= rate_now;
    end
  end

  // Decimation factor per code; only the notch spacing changes, not the shape
  always_comb begin
    unique case (rate_ff)
      2'h0: dec_n = DEC_CNT_W'(DEC_N0);
      2'h1: dec_n = DEC_CNT_W'(DEC_N1);
      2'h2: dec_n = DEC_CNT_W'(DEC_N2);
      2'h3: dec_n = DEC_CNT_W'(DEC_N3);
    endcase
  end

  // ---------------------------------------------------------------------------
  // Integrators at the modulator rate
  // ---------------------------------------------------------------------------
  logic [ACC_W-1:0] integ_ff [SINC_ORDER];
  logic [ACC_W-1:0] nxt_integ [SINC_ORDER];
  logic [ACC_W-1:0] sample_x;

  // Modulator bit weighs 0 or 1; full scale of a word is N^3
  assign sample_x = {{(ACC_W-1){1'b0}}, mod_bit_i};

  // Wrap-around is safe as the combs cancel it; no lag between stages keeps settling exact
  generate
    for (genvar s = 0; s < SINC_ORDER; s++) begin : g_integ
      assign nxt_integ[s] = integ_ff[s] + ((s == 0) ? sample_x : nxt_integ[(s == 0) ? 0 : s-1]);
      always_ff @(posedge clk_sys_i) begin
        if (reset_i || filter_resync_i) begin
          integ_ff[s] <= '0;
        end else if (mod_tick_ff) begin
          integ_ff[s] <= nxt_integ[s];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Decimation counter
  // ---------------------------------------------------------------------------
  logic [DEC_CNT_W-1:0] dec_cnt_ff;
  logic                 dump;

  assign dump = mod_tick_ff && (dec_cnt_ff == dec_n - DEC_CNT_W'(1));

  // One dump per N modulator samples; the rest are discarded
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || filter_resync_i || rate_change) begin
      dec_cnt_ff <= '0;
    end else if (dump) begin
      dec_cnt_ff <= '0;
    end else if (mod_tick_ff) begin
      dec_cnt_ff <= dec_cnt_ff + DEC_CNT_W'(1);
    end
  end

  // ---------------------------------------------------------------------------
  // Combs at the output rate
  // ---------------------------------------------------------------------------
  logic [ACC_W-1:0] comb_dly_ff [SINC_ORDER];
  logic [ACC_W-1:0] comb_in     [SINC_ORDER];
  logic [ACC_W-1:0] comb_out    [SINC_ORDER];

  // Equal-length combs give linear phase and notches at multiples of the rate
  generate
    for (genvar s = 0; s < SINC_ORDER; s++) begin : g_comb
      assign comb_in[s]  = (s == 0) ? nxt_integ[SINC_ORDER-1] : comb_out[(s == 0) ? 0 : s-1];
      assign comb_out[s] = comb_in[s] - comb_dly_ff[s];
      always_ff @(posedge clk_sys_i) begin
        if (reset_i || filter_resync_i) begin
          comb_dly_ff[s] <= '0;
        end else if (dump) begin
          comb_dly_ff[s] <= comb_in[s];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Settling and word strobe
  // ---------------------------------------------------------------------------
  logic [1:0]       skip_ff;
  logic             word_strobe_ff;
  logic [ACC_W-1:0] word_ff;
  logic             fifo_in_ready;
  logic             overrun_ff;

  // Words still inside the pipeline fill are withheld, not flagged
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || rate_change) begin
      skip_ff <= SKIP_FREE;
    end else if (filter_resync_i) begin
      skip_ff <= SKIP_SYNC;
    end else if (dump && skip_ff != 2'h0) begin
      skip_ff <= skip_ff - 2'h1;
    end
  end

  // One-cycle strobe with each settled word
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || filter_resync_i) begin
      word_strobe_ff <= 1'b0;
      word_ff        <= '0;
    end else begin
      word_strobe_ff <= dump && (skip_ff == 2'h0) && !rate_change;
      if (dump) begin
        word_ff <= comb_out[SINC_ORDER-1];
      end
    end
  end
  assign word_strobe_o = word_strobe_ff;

  // The modulator cannot be stalled, so a full FIFO loses the word and says so;
  // a loss in the resync cycle wins over the clear so it is never hidden
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      overrun_ff <= 1'b0;
    end else if (word_strobe_ff && !fifo_in_ready) begin
      overrun_ff <= 1'b1;
    end else if (filter_resync_i) begin
      overrun_ff <= 1'b0;
    end
  end
  assign overrun_o = overrun_ff;

  // ---------------------------------------------------------------------------
  // Output buffer and output register
  // ---------------------------------------------------------------------------
  logic             fifo_out_valid;
  logic [ACC_W-1:0] fifo_out_data;
  logic             fifo_pop;
  logic             out_valid_ff;
  logic [ACC_W-1:0] out_data_ff;

  assign fifo_pop = fifo_out_valid && (!out_valid_ff || out_ready_i);

  scf_fifo #(
    .WIDTH (ACC_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .in_valid_i  (word_strobe_ff),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (word_ff),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

  // Registered output stage so the ports come from flops
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (fifo_pop) begin
      out_valid_ff <= 1'b1;
      out_data_ff  <= fifo_out_data;
    end else if (out_ready_i) begin
      out_valid_ff <= 1'b0;
    end
  end
  assign out_valid_o = out_valid_ff;
  assign out_data_o  = out_data_ff;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_mod_tick_period: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    mod_tick_ff |-> $past(presc_ff) == PRESC_W'(MOD_DIV - 1))
    else $error("modulator tick off the divide-by-128 point");

  chk_tick_spacing: assert property (@(posedge clk_sys_i) disable iff (reset_i || filter_resync_i)
    mod_tick_ff |=> !mod_tick_ff [*8])
    else $error("modulator ticks too close");

  chk_dec_bound: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    dec_cnt_ff < dec_n || $past(rate_change))
    else $error("decimation counter past N");

  chk_dump_point: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    dump |=> dec_cnt_ff == '0)
    else $error("counter not restarted at dump");

  chk_sync_skip: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    filter_resync_i && !rate_change |=> skip_ff == 2'h2 && integ_ff[0] == '0)
    else $error("resync did not arm the three-period settle");

  chk_free_skip: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rate_change |=> skip_ff == 2'h3 && dec_cnt_ff == '0)
    else $error("rate change did not arm the four-period settle");

  chk_strobe_single: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    word_strobe_ff |=> !word_strobe_ff)
    else $error("word strobe longer than one cycle");

  chk_strobe_settled: assert property (@(posedge clk_sys_i) disable iff (reset_i || filter_resync_i)
    word_strobe_ff |-> $past(dump) && $past(skip_ff) == 2'h0)
    else $error("word released before settling");

  chk_out_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    out_valid_ff && !out_ready_i |=> out_valid_ff && $stable(out_data_ff))
    else $error("output word dropped under back-pressure");

  cov_first_word: cover property (@(posedge clk_sys_i) disable iff (reset_i) word_strobe_ff);
  cov_resync_word: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    filter_resync_i ##1 (!filter_resync_i) [*8] ##[1:1000] dump);
  cov_rate_change: cover property (@(posedge clk_sys_i) disable iff (reset_i) rate_change);
  cov_overrun: cover property (@(posedge clk_sys_i) disable iff (reset_i) $rose(overrun_ff));

endmodule : scf_sinc3_filter

// ==== sim/scf_mod_model.sv ====
`timescale 1ns/100ps

// ---------------------------------------------------------------------------
// Modulator bitstream source
// ---------------------------------------------------------------------------
module scf_mod_model (
  input  wire logic       clk_sys_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] pattern_i,
  output logic            bit_o
);
  logic alt_ff = 1'b0;
  logic bit_ff = 1'b0;
  logic pat_bit;

  assign bit_o = bit_ff;

  // Pattern 0 is all zeros, 1 all ones, 2 alternating per sample
  assign pat_bit = (pattern_i == 2'h0) ? 1'b0 : (pattern_i == 2'h1) ? 1'b1 : alt_ff;

  // Bit is only meaningful in the tick cycle; off-tick the inverse is shown so a
  // filter sampling at the wrong moment integrates garbage
  always @(negedge clk_sys_i) begin
    if (tick_i === 1'b1) begin
      bit_ff <= pat_bit;
      alt_ff <= ~alt_ff;
    end else begin
      bit_ff <= ~pat_bit;
    end
  end
endmodule : scf_mod_model

// ==== sim/scf_sinc3_filter_bench.sv ====
`timescale 1ns/100ps

`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected %s: expected %0d seen %0d", what, exp, got); end end

// ---------------------------------------------------------------------------
// Bench top
// ---------------------------------------------------------------------------
module scf_sinc3_filter_bench;
  import scf_pkg::*;
  localparam int W = ACC_W_DEF;
  localparam int NT[4] = '{8, 6, 4, 5};  // Short decimation factors keep the run small
  logic         clk_sys_i = 1'b0;
  logic         reset_i   = 1'b1;
  logic         rsel_lo   = 1'b0;
  logic         rsel_hi   = 1'b0;
  logic         resync    = 1'b0;
  logic         out_ready = 1'b1;
  logic [1:0]   pattern   = 2'h1;
  wire          mod_bit;
  wire          mod_tick;
  wire          word_strobe;
  wire          out_valid;
  wire [W-1:0]  out_data;
  wire          overrun;
  int           error_cnt = 0;
  int           n_tests   = 0;
  int           cyc       = 0;
  int           t_strobe  = 0;
  int           t0        = 0;

  scf_sinc3_filter #(.ACC_W(W), .DEC_N0(8), .DEC_N1(6), .DEC_N2(4), .DEC_N3(5),
    .FIFO_DEPTH(4)) dut_u (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .mod_bit_i(mod_bit),
    .rate_select_lo_i(rsel_lo), .rate_select_hi_i(rsel_hi), .filter_resync_i(resync),
    .out_ready_i(out_ready), .mod_tick_o(mod_tick), .word_strobe_o(word_strobe),
    .out_valid_o(out_valid), .out_data_o(out_data), .overrun_o(overrun));

  scf_mod_model mod_u (.clk_sys_i(clk_sys_i), .tick_i(mod_tick), .pattern_i(pattern),
    .bit_o(mod_bit));

  always #5 clk_sys_i = ~clk_sys_i;

  // Cycle stamp of the latest word strobe, for period measurements
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (word_strobe === 1'b1) t_strobe <= cyc;
  end

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic timeout_hit(input string what);
    error_cnt++;
    $display("unexpected %s: expected event seen timeout", what);
    summarize();
  endtask : timeout_hit

  // Bounded wait for one word strobe, then confirm it lasted one cycle
  task automatic wait_strobe(input int bound);
    int i;
    for (i = 0; i < bound; i++) begin
      @(negedge clk_sys_i);
      if (word_strobe === 1'b1) break;
    end
    if (i == bound) timeout_hit("word strobe");
    @(negedge clk_sys_i);
    `CHK("strobe width", 1'b0, word_strobe)
  endtask : wait_strobe

  // Ready is high, so the word shown at a negedge is taken at the next edge
  task automatic get_word(output logic [W-1:0] w);
    int i;
    for (i = 0; i < 64; i++) begin
      if (out_valid === 1'b1) break;
      @(negedge clk_sys_i);
    end
    if (i == 64) timeout_hit("out valid");
    w = out_data;
    @(negedge clk_sys_i);
  endtask : get_word

  task automatic set_code(input int c);
    @(negedge clk_sys_i);
    {rsel_hi, rsel_lo} = c[1:0];
    repeat (2) @(negedge clk_sys_i);
  endtask : set_code

  task automatic pulse_resync;
    @(negedge clk_sys_i);
    resync = 1'b1;
    @(negedge clk_sys_i);
    resync = 1'b0;
    t0 = cyc;
  endtask : pulse_resync

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Sample tick spacing straight out of reset
  task automatic test_tick;
    int k;
    int k1;
    k1 = 0;
    for (k = 1; k < 300; k++) begin
      @(negedge clk_sys_i);
      if (mod_tick === 1'b1 && k1 == 0) k1 = k;
      else if (mod_tick === 1'b1) break;
    end
    `CHK("first tick", 128, k1)
    `CHK("tick gap", MOD_DIV, k - k1)
  endtask : test_tick

  // Every rate code: word period and settled full-scale value
  task automatic test_codes;
    logic [W-1:0] w;
    int           t1;
    for (int c = 0; c < 4; c++) begin
      set_code(c);
      wait_strobe(5 * NT[c] * 128 + 50);
      t1 = t_strobe;
      get_word(w);
      `CHK("word after rate change", W'(NT[c] ** 3), w)
      wait_strobe(NT[c] * 128 + 50);
      `CHK("word period", NT[c] * 128, t_strobe - t1)
      get_word(w);
      `CHK("steady word", W'(NT[c] ** 3), w)
    end
  endtask : test_codes

  // Alternating, full and zero input, then an unaligned step
  task automatic test_patterns;
    logic [W-1:0] w;
    logic [1:0]   pl[3] = '{2'h2, 2'h1, 2'h0};
    int           ex[3] = '{256, 512, 0};
    set_code(0);
    for (int p = 0; p < 3; p++) begin
      pattern = pl[p];
      pulse_resync();
      wait_strobe(4 * 1024);
      get_word(w);
      `CHK("pattern word", W'(ex[p]), w)
    end
    pattern = 2'h1;
    repeat (4) begin
      wait_strobe(NT[0] * 128 + 50);
      get_word(w);
    end
    `CHK("word after step", W'(512), w)
  endtask : test_patterns

  // Resync latency and restart of the pipeline
  task automatic test_resync;
    logic [W-1:0] w;
    set_code(3);
    pulse_resync();
    wait_strobe(4 * 640);
    `CHK("resync latency", 1'b1, (t_strobe - t0 >= 1916) && (t_strobe - t0 <= 1924))
    get_word(w);
    `CHK("resync word", W'(125), w)
  endtask : test_resync

  // Stalled consumer: fill to refusal, then drain to empty
  task automatic test_overrun;
    int cnt;
    cnt = 0;
    set_code(2);
    out_ready = 1'b0;
    pulse_resync();
    repeat (5) wait_strobe(4 * 512);
    repeat (4) @(negedge clk_sys_i);
    `CHK("overrun while room", 1'b0, overrun)
    repeat (512 + 20) @(negedge clk_sys_i);
    `CHK("overrun after loss", 1'b1, overrun)
    out_ready = 1'b1;
    repeat (40) begin
      if (out_valid === 1'b1) begin
        cnt++;
        `CHK("drained word", W'(64), out_data)
      end
      @(negedge clk_sys_i);
    end
    `CHK("words kept", 5, cnt)
    `CHK("empty after drain", 1'b0, out_valid)
    pulse_resync();
    @(negedge clk_sys_i);
    `CHK("overrun cleared", 1'b0, overrun)
  endtask : test_overrun

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    timeout_hit("run length");
  end

  initial begin
    repeat (5) @(negedge clk_sys_i);
    `CHK("valid in reset", 1'b0, out_valid)
    reset_i = 1'b0;
    test_tick();
    test_codes();
    test_patterns();
    test_resync();
    test_overrun();
    summarize();
  end
endmodule : scf_sinc3_filter_bench
